// ===== aif_pkg.sv
// constants and types shared by the interrupt flag block
package aif_pkg;

   // ************************************************************
   // register map (apb byte addresses)
   // ************************************************************
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_LOCK     = 8'h04;
   localparam logic [7:0] ADDR_CONV_LEN = 8'h08;
   localparam logic [7:0] ADDR_IRQ      = 8'h0c;
   localparam logic [7:0] ADDR_STATE    = 8'h10;

   // ************************************************************
   // control register fields and reset values
   // ************************************************************
   localparam int         CTRL_START_PULSE_EN = 0;
   localparam int         CTRL_PIN_MODE       = 1;
   localparam int         CTRL_BITSTREAM_SEL  = 2;
   localparam int         CTRL_AUTO_RELEASE   = 3;
   localparam int         CTRL_W              = 4;
   localparam logic [3:0] CTRL_RESET          = 4'h1;

   localparam logic [7:0] LOCK_KEY   = 8'ha5;
   localparam logic [7:0] LOCK_RESET = 8'ha5;

   localparam int          CONV_LEN_W     = 24;
   localparam logic [23:0] CONV_LEN_RESET = 24'h000100;

   // ************************************************************
   // timing, in modulator clock periods
   // ************************************************************
   localparam int STARTUP_DELAY_MODULATOR_CLOCK = 256;
   localparam int EARLY_RELEASE_MODULATOR_CLOCK = 16;
   localparam int START_PULSE_MODULATOR_CLOCK   = 2;

   // ************************************************************
   // flag vector, active low, and pin state bits
   // ************************************************************
   typedef struct packed {
      logic por_n;
      logic cfg_n;
      logic ready_n;
   } aif_flags_s;

   localparam logic [2:0] FLAGS_POWER_UP = 3'h3;
   localparam int         FLAGS_W        = 3;
   localparam int         STATE_W        = 5;

   typedef enum {ST_IDLE, ST_DELAY, ST_PULSE} aif_start_e;

endpackage : aif_pkg

// ===== aif_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none

module aif_sync #(
   parameter int         W     = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // pins in, synchronised out
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);

   logic [W-1:0] stage1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage1 <= RST;
         dout   <= RST;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule : aif_sync

`default_nettype wire

// ===== aif_irq_flags.sv
// interrupt flag logic: status byte, interrupt register and interrupt pin
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - data ready shows low in next status byte, high after it is sent
// - data ready clears register bit to 0; full read sets it back
// - data ready pulls the interrupt pin low at once
// - pin released at first sck fall of result read or 16 periods early
// - conversion start appears only on the pin, never in flags
// - start pulse enable gates the start event, default on
// - start event raised after 256 modulator periods start-up delay
// - start pulse returns the pin high by itself after fixed width
// - power-up shows low in first status byte, then high
// - power-up clears register bit to 0; full read restores it
// - supply monitor low holds the pin low
// - power pin assertion cleared only by cs fall with good supplies
// - power assertion forces pin low over the modulator bitstream
// - checksum mismatch raises the configuration error event
// - configuration error shows low in next status byte
// - configuration error clears register bit; full read restores it
// - pin mode 1 lets only power, configuration errors and the bitstream drive pin
// - configuration error holds pin until key written or restart
// - configuration error beats all but power, the bitstream included
// - status flags captured at address match, shifted every command
module aif_irq_flags #(
   parameter int START_DELAY = aif_pkg::STARTUP_DELAY_MODULATOR_CLOCK,
   parameter int PULSE_WIDTH = aif_pkg::START_PULSE_MODULATOR_CLOCK,
   parameter int LEN_W       = aif_pkg::CONV_LEN_W
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output var  logic [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // pins from the host and supply monitors
   input  wire logic               sck,
   input  wire logic               cs_n,
   input  wire logic               avdd_ok,
   input  wire logic               dvdd_ok,
   // converter core, same clock
   input  wire logic               modulator_clock,
   input  wire logic               result_ready,
   input  wire logic               conv_start_req,
   input  wire logic               fast_restart,
   input  wire logic               cfg_checksum_error,
   input  wire logic               conversion_result_read,
   input  wire logic               addr_recognised,
   input  wire logic               status_byte_done,
   input  wire logic               modulator_bitstream_out,
   // outputs
   output var  aif_pkg::aif_flags_s status_flags,
   output var  logic               irq_n
);

   // ************************************************************
   // helpers
   // ************************************************************
   localparam int DLY_W = $clog2(START_DELAY + 1);
   localparam int PW_W  = $clog2(PULSE_WIDTH + 1);

   function automatic logic addr_mapped(input logic [7:0] a);
      if (a == aif_pkg::ADDR_CTRL) addr_mapped = 1'b1;
      else if (a == aif_pkg::ADDR_LOCK) addr_mapped = 1'b1;
      else if (a == aif_pkg::ADDR_CONV_LEN) addr_mapped = 1'b1;
      else if (a == aif_pkg::ADDR_IRQ) addr_mapped = 1'b1;
      else if (a == aif_pkg::ADDR_STATE) addr_mapped = 1'b1;
      else addr_mapped = 1'b0;
   endfunction : addr_mapped

   // an event always wins over the clear at the end of a read
   function automatic logic [2:0] flag_next(input logic [2:0] flag_n,
                                            input logic [2:0] ev,
                                            input logic [2:0] seen,
                                            input logic       done);
      flag_next = ~ev & (flag_n | ({3{done}} & ~seen));
   endfunction : flag_next

   // ************************************************************
   // pin synchronisers and edge detection
   // ************************************************************
   logic [3:0] pins_s;
   logic       sck_s;
   logic       cs_n_s;
   logic       supply_good;
   logic       sck_d;
   logic       cs_n_d;
   logic       sck_fall;
   logic       cs_fall;

   aif_sync #(.W(4), .RST(4'h2)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({dvdd_ok, avdd_ok, cs_n, sck}),
      .dout    (pins_s)
   );

   assign sck_s       = pins_s[0];
   assign cs_n_s      = pins_s[1];
   assign supply_good = pins_s[2] & pins_s[3];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_d  <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sck_d  <= sck_s;
         cs_n_d <= cs_n_s;
      end
   end

   assign sck_fall = sck_d & ~sck_s;
   assign cs_fall  = cs_n_d & ~cs_n_s;

   // ************************************************************
   // apb registers
   // ************************************************************
   logic [aif_pkg::CTRL_W-1:0] ctrl;
   logic [7:0]                 lock;
   logic [LEN_W-1:0]           conv_len;
   logic                       apb_setup;
   logic                       apb_access;
   logic                       wr_access;
   logic                       irq_rd_setup;
   logic                       irq_rd_done;
   logic                       key_write;
   logic                       start_en;
   logic                       pin_mode;
   logic                       bits_sel;
   logic                       auto_rel;

   assign apb_setup    = psel & ~penable;
   assign apb_access   = psel & penable;
   assign wr_access    = apb_access & pwrite & addr_mapped(paddr);
   assign irq_rd_setup = apb_setup & ~pwrite & (paddr == aif_pkg::ADDR_IRQ);
   assign irq_rd_done  = apb_access & ~pwrite & (paddr == aif_pkg::ADDR_IRQ);
   assign key_write    = wr_access & (paddr == aif_pkg::ADDR_LOCK)
                         & (pwdata[7:0] == aif_pkg::LOCK_KEY);
   assign pready       = 1'b1;
   assign pslverr      = apb_access & ~addr_mapped(paddr);

   assign start_en = ctrl[aif_pkg::CTRL_START_PULSE_EN];
   assign pin_mode = ctrl[aif_pkg::CTRL_PIN_MODE];
   assign bits_sel = ctrl[aif_pkg::CTRL_BITSTREAM_SEL];
   assign auto_rel = ctrl[aif_pkg::CTRL_AUTO_RELEASE];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= aif_pkg::CTRL_RESET;
         lock     <= aif_pkg::LOCK_RESET;
         conv_len <= aif_pkg::CONV_LEN_RESET;
      end else if (wr_access) begin
         if (paddr == aif_pkg::ADDR_CTRL) ctrl <= pwdata[aif_pkg::CTRL_W-1:0];
         else if (paddr == aif_pkg::ADDR_LOCK) lock <= pwdata[7:0];
         else if (paddr == aif_pkg::ADDR_CONV_LEN) conv_len <= pwdata[LEN_W-1:0];
      end
   end

   // ************************************************************
   // events feeding the two flag paths
   // ************************************************************
   logic [2:0] ev;
   logic [2:0] sb_flag_n;
   logic [2:0] sb_seen;
   logic [2:0] rg_flag_n;
   logic [2:0] rg_seen;

   // start request has no bit here: start is a pin-only event
   assign ev = {~supply_good, cfg_checksum_error, result_ready};

   // status byte path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb_flag_n    <= aif_pkg::FLAGS_POWER_UP;
         sb_seen      <= '0;
         status_flags <= aif_pkg::FLAGS_POWER_UP;
      end else begin
         sb_flag_n <= flag_next(sb_flag_n, ev, sb_seen, status_byte_done);
         if (addr_recognised) begin
            status_flags <= sb_flag_n & ~ev;
            sb_seen      <= ev;
         end else begin
            sb_seen <= sb_seen | ev;
         end
      end
   end

   // interrupt register path, latched at read setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rg_flag_n <= aif_pkg::FLAGS_POWER_UP;
         rg_seen   <= '0;
      end else begin
         rg_flag_n <= flag_next(rg_flag_n, ev, rg_seen, irq_rd_done);
         rg_seen   <= irq_rd_setup ? ev : (rg_seen | ev);
      end
   end

   // ************************************************************
   // data ready pin latch and early release counter
   // ************************************************************
   logic             dr_pin;
   logic [LEN_W-1:0] remain;
   logic             early_rel;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain <= '0;
      end else if (result_ready) begin
         remain <= conv_len;
      end else if (modulator_clock && remain != '0) begin
         remain <= remain - LEN_W'(1);
      end
   end

   assign early_rel = auto_rel & (remain == LEN_W'(aif_pkg::EARLY_RELEASE_MODULATOR_CLOCK));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dr_pin <= 1'b0;
      end else if (result_ready) begin
         dr_pin <= 1'b1;
      end else if ((sck_fall && conversion_result_read) || early_rel) begin
         dr_pin <= 1'b0;
      end
   end

   // ************************************************************
   // conversion start pulse
   // ************************************************************
   aif_pkg::aif_start_e start_state;
   logic [DLY_W-1:0]    dly_cnt;
   logic [PW_W-1:0]     pw_cnt;
   logic                start_pin;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_state <= aif_pkg::ST_IDLE;
         dly_cnt     <= '0;
         pw_cnt      <= '0;
      end else begin
         case (start_state)
            aif_pkg::ST_IDLE: begin
               dly_cnt <= '0;
               pw_cnt  <= '0;
               if (conv_start_req || fast_restart) start_state <= aif_pkg::ST_DELAY;
            end
            aif_pkg::ST_DELAY: begin
               if (modulator_clock) begin
                  dly_cnt <= dly_cnt + DLY_W'(1);
                  if (dly_cnt == DLY_W'(START_DELAY - 1)) begin
                     start_state <= aif_pkg::ST_PULSE;
                  end
               end
            end
            aif_pkg::ST_PULSE: begin
               if (modulator_clock) begin
                  pw_cnt <= pw_cnt + PW_W'(1);
                  if (pw_cnt == PW_W'(PULSE_WIDTH - 1)) begin
                     start_state <= aif_pkg::ST_IDLE;
                  end
               end
            end
            default: start_state <= aif_pkg::ST_IDLE;
         endcase
      end
   end

   assign start_pin = (start_state == aif_pkg::ST_PULSE) & start_en;

   // ************************************************************
   // power and configuration error pin latches
   // ************************************************************
   logic por_pin;
   logic crc_pin;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_pin <= 1'b1;
      end else if (!supply_good) begin
         por_pin <= 1'b1;
      end else if (cs_fall) begin
         por_pin <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_pin <= 1'b0;
      end else if (cfg_checksum_error) begin
         crc_pin <= 1'b1;
      end else if (key_write || fast_restart) begin
         crc_pin <= 1'b0;
      end
   end

   // ************************************************************
   // interrupt pin priority mux
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_n <= 1'b0;
      end else if (por_pin) begin
         irq_n <= 1'b0;
      end else if (crc_pin) begin
         irq_n <= 1'b0;
      end else if (bits_sel) begin
         irq_n <= modulator_bitstream_out;
      end else if (!pin_mode && (dr_pin || start_pin)) begin
         irq_n <= 1'b0;
      end else begin
         irq_n <= 1'b1;
      end
   end

   // ************************************************************
   // read data, loaded in the setup phase
   // ************************************************************
   logic [aif_pkg::STATE_W-1:0] pin_state;

   assign pin_state = {start_pin, dr_pin, crc_pin, por_pin, irq_n};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (apb_setup && !pwrite) begin
         if (paddr == aif_pkg::ADDR_CTRL) prdata <= 32'(ctrl);
         else if (paddr == aif_pkg::ADDR_LOCK) prdata <= 32'(lock);
         else if (paddr == aif_pkg::ADDR_CONV_LEN) prdata <= 32'(conv_len);
         else if (paddr == aif_pkg::ADDR_IRQ) prdata <= 32'(rg_flag_n & ~ev);
         else if (paddr == aif_pkg::ADDR_STATE) prdata <= 32'(pin_state);
         else prdata <= '0;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ready_then_capture;
      result_ready && !addr_recognised ##1 !addr_recognised ##1 addr_recognised;
   endsequence

   sequence s_ready_then_irq_read;
      result_ready && !irq_rd_setup ##1 !irq_rd_setup ##1 irq_rd_setup;
   endsequence

   property p_sb_ready;
      s_ready_then_capture |=> !status_flags.ready_n;
   endproperty
   a_sb_ready: assert property (p_sb_ready) else $error("ready missing in status");

   property p_rg_ready;
      s_ready_then_irq_read |=> !prdata[0];
   endproperty
   a_rg_ready: assert property (p_rg_ready) else $error("ready missing in register");

   property p_pin_ready;
      result_ready && !pin_mode && !bits_sel |-> ##2 !irq_n;
   endproperty
   a_pin_ready: assert property (p_pin_ready) else $error("ready did not pull pin");

   property p_read_release;
      sck_fall && conversion_result_read && !result_ready |=> !dr_pin;
   endproperty
   a_read_release: assert property (p_read_release) else $error("ready not released");

   property p_start_gate;
      start_state == aif_pkg::ST_PULSE && !start_en && !dr_pin
         && !por_pin && !crc_pin && !bits_sel |=> irq_n;
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("start pulse not gated");

   property p_start_delay;
      start_state == aif_pkg::ST_DELAY && modulator_clock
         && dly_cnt == DLY_W'(START_DELAY - 1) |=> start_state == aif_pkg::ST_PULSE;
   endproperty
   a_start_delay: assert property (p_start_delay) else $error("start delay wrong");

   property p_supply_low;
      !supply_good |-> ##2 !irq_n;
   endproperty
   a_supply_low: assert property (p_supply_low) else $error("supply low not on pin");

   property p_por_clear;
      $fell(por_pin) |-> $past(cs_fall) && $past(supply_good);
   endproperty
   a_por_clear: assert property (p_por_clear) else $error("power pin cleared badly");

   property p_crc_clear;
      key_write && !cfg_checksum_error |=> !crc_pin;
   endproperty
   a_crc_clear: assert property (p_crc_clear) else $error("key did not clear error");

   property p_pin_mode;
      pin_mode && !por_pin && !crc_pin && !bits_sel |=> irq_n;
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("pin mode not honoured");

endmodule : aif_irq_flags

`default_nettype wire

// ===== aif_host_model.sv
// host side model: chip select and serial clock, watches the interrupt pin
`timescale 1ns/1ns
`default_nettype none

module aif_host_model (
   // link pins
   output var  logic sck,
   output var  logic cs_n,
   // interrupt pin from the device
   input  wire logic irq_n
);
   // pin level seen by the host at the end of its last frame
   logic irq_seen;

   // serial clock stands low outside frames
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
   end

   // one frame: cs falls, n periods of 160 ns, cs rises; host then polls irq_n
   task automatic frame(input int n);
      #37 cs_n = 1'b0;
      repeat (n) begin
         #80 sck = 1'b1;
         #80 sck = 1'b0;
      end
      #80 cs_n = 1'b1;
      #80;
      irq_seen = irq_n;
   endtask : frame
endmodule : aif_host_model
`default_nettype wire

// ===== aif_irq_flags_tb_top.sv
// self-checking testbench of the interrupt flag block
`timescale 1ns/1ns
`default_nettype none

module aif_irq_flags_tb_top;
   logic                pclk;
   logic                presetn;
   logic [7:0]          paddr;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic                sck;
   logic                cs_n;
   logic                avdd_ok;
   logic                dvdd_ok;
   logic                mod_clk = 1'b0;
   logic [1:0]          mod_cnt = 2'h0;
   logic [5:0]          ev;
   logic                res_read;
   logic                bits_out;
   aif_pkg::aif_flags_s status_flags;
   logic                irq_n;
   logic [31:0]         rd;
   logic                err;
   int                  bad_count;
   int                  samples_checked;

   aif_irq_flags #(.START_DELAY(4)) i_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sck(sck), .cs_n(cs_n),
      .avdd_ok(avdd_ok), .dvdd_ok(dvdd_ok), .modulator_clock(mod_clk),
      .result_ready(ev[0]), .conv_start_req(ev[1]), .fast_restart(ev[2]),
      .cfg_checksum_error(ev[3]), .conversion_result_read(res_read),
      .addr_recognised(ev[4]), .status_byte_done(ev[5]),
      .modulator_bitstream_out(bits_out), .status_flags(status_flags),
      .irq_n(irq_n));

   aif_host_model i_host (.sck(sck), .cs_n(cs_n), .irq_n(irq_n));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // one modulator period every four bus clocks
   always @(posedge pclk) begin
      mod_cnt <= mod_cnt + 2'h1;
      mod_clk <= (mod_cnt == 2'h3);
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("prdata", exp, rd);
   endtask : rdchk

   task automatic pin(input logic v);
      int n;
      n = 0;
      while (irq_n !== v && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk("irq_n", {31'h0, v}, {31'h0, irq_n});
   endtask : pin

   task automatic hold(input logic v, input int cyc);
      logic ok;
      ok = 1'b1;
      repeat (cyc) begin
         @(posedge pclk);
         if (irq_n !== v) ok = 1'b0;
      end
      chk("irq_n steady", 32'h1, {31'h0, ok});
   endtask : hold

   task automatic pulse(input int i);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev[i] <= 1'b0;
      @(posedge pclk);
   endtask : pulse

   task automatic status(input logic [2:0] exp);
      pulse(4);
      @(posedge pclk);
      chk("status_flags", {29'h0, exp}, {29'h0, status_flags});
      pulse(5);
   endtask : status

   task automatic cs(input int n);
      i_host.frame(n);
      @(posedge pclk);
   endtask : cs

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_power();
      hold(1'b0, 10);
      cs(0);
      chk("host irq_n", 32'h0, {31'h0, i_host.irq_seen});
      hold(1'b0, 10);
      avdd_ok <= 1'b1;
      hold(1'b0, 10);
      cs(0);
      chk("host irq_n", 32'h1, {31'h0, i_host.irq_seen});
      pin(1'b1);
      status(3'h3);
      status(3'h7);
      rdchk(aif_pkg::ADDR_IRQ, 32'h3);
      rdchk(aif_pkg::ADDR_IRQ, 32'h7);
      rdchk(aif_pkg::ADDR_CTRL, 32'h1);
      rdchk(aif_pkg::ADDR_CONV_LEN, 32'h100);
      apb(1'b0, 8'h14, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      chk("prdata", 32'h0, rd);
   endtask : t_power

   task automatic t_ready();
      pulse(0);
      pin(1'b0);
      rdchk(aif_pkg::ADDR_IRQ, 32'h6);
      pulse(0);
      rdchk(aif_pkg::ADDR_IRQ, 32'h6);
      rdchk(aif_pkg::ADDR_IRQ, 32'h7);
      status(3'h6);
      status(3'h7);
      hold(1'b0, 5);
      res_read <= 1'b1;
      cs(4);
      pin(1'b1);
      res_read <= 1'b0;
      apb(1'b1, aif_pkg::ADDR_CONV_LEN, 32'h20);
      apb(1'b1, aif_pkg::ADDR_CTRL, 32'h9);
      pulse(0);
      status(3'h6);
      hold(1'b0, 50);
      pin(1'b1);
      rdchk(aif_pkg::ADDR_IRQ, 32'h6);
   endtask : t_ready

   task automatic t_start();
      apb(1'b1, aif_pkg::ADDR_CTRL, 32'h1);
      pulse(1);
      hold(1'b1, 8);
      pin(1'b0);
      pin(1'b1);
      status(3'h7);
      rdchk(aif_pkg::ADDR_IRQ, 32'h7);
      apb(1'b1, aif_pkg::ADDR_CTRL, 32'h0);
      pulse(1);
      hold(1'b1, 60);
      apb(1'b1, aif_pkg::ADDR_CTRL, 32'h3);
      pulse(1);
      hold(1'b1, 60);
   endtask : t_start

   task automatic t_cfg();
      apb(1'b1, aif_pkg::ADDR_LOCK, 32'h0);
      apb(1'b1, aif_pkg::ADDR_CTRL, 32'h6);
      bits_out <= 1'b1;
      pulse(0);
      hold(1'b1, 10);
      pulse(3);
      pin(1'b0);
      rdchk(aif_pkg::ADDR_STATE, 32'hc);
      rdchk(aif_pkg::ADDR_IRQ, 32'h4);
      rdchk(aif_pkg::ADDR_IRQ, 32'h7);
      status(3'h4);
      status(3'h7);
      hold(1'b0, 5);
      apb(1'b1, aif_pkg::ADDR_LOCK, 32'ha5);
      pin(1'b1);
      apb(1'b1, aif_pkg::ADDR_LOCK, 32'h0);
      pulse(3);
      pin(1'b0);
      pulse(2);
      pin(1'b1);
   endtask : t_cfg

   task automatic t_supply();
      apb(1'b1, aif_pkg::ADDR_CTRL, 32'h5);
      pin(1'b1);
      dvdd_ok <= 1'b0;
      pin(1'b0);
      dvdd_ok <= 1'b1;
      hold(1'b0, 10);
      cs(0);
      pin(1'b1);
      rdchk(aif_pkg::ADDR_IRQ, 32'h1);
   endtask : t_supply

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize

   initial begin
      #200000;
      bad_count++;
      summarize();
   end

   initial begin
      bad_count = 0;
      samples_checked = 0;
      presetn = 1'b0;
      {paddr, psel, penable, pwrite, pwdata} = '0;
      {avdd_ok, dvdd_ok} = 2'h1;
      {ev, res_read, bits_out} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_power();
      t_ready();
      t_start();
      t_cfg();
      t_supply();
      summarize();
   end
endmodule : aif_irq_flags_tb_top
`default_nettype wire
